// ==== spmc_mode_control.sv ====
// Sleep, start-up, gate drive and supply-select control for a source port.
//
// Summary of operation
// [RULE1] The block sleeps whenever no valid termination is seen on the channel.
// [RULE2] Only sink, audio accessory and debug accessory terminations keep it awake.
// [RULE3] An active cable with nothing at its far end also sends it to sleep.
// [RULE4] Any change of plug status wakes it from sleep.
// [RULE5] At first power-up the gate drive stays off if bus voltage is already above lockout.
// [RULE6] A 12 V request pulls the low supply select low and releases the high one.
// [RULE7] A 20 V request pulls both supply selects low.
// [RULE8] A thermal trip resets all control logic to its initial state.
// [RULE9] The default 5 V level releases both supply selects.
// [RULE10] A falling edge on the gate override input turns the gate drive off at once.
// [RULE11] Override held low 600 ms after sink attach sends a hard reset and restarts.
// [RULE12] On waking, attach debouncing starts over before any termination is acted on.
`timescale 1ns/1ns
`include "spmc_regs.svh"
module spmc_mode_control
  import spmc_pkg::*;
#(
  parameter int GD_HOLD_CYCLES = `SPMC_GD_HOLD_CYCLES,
  parameter int DEBOUNCE_CYCLES = `SPMC_DEBOUNCE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic thermal_shutdown,
  input wire spmc_term_t termination,
  input wire logic vbus_above_uvlo,
  input wire spmc_vsel_t requested_level,
  input wire logic gate_override_n,
  output logic sleep,
  output logic power_path_gate_drive,
  output logic supply_select_low_out,
  output logic supply_select_low_oe,
  output logic supply_select_high_out,
  output logic supply_select_high_oe,
  output logic core_supply_output,
  output logic hard_reset
);
  localparam int CW = 32;
  if (GD_HOLD_CYCLES < 1 || DEBOUNCE_CYCLES < 1) begin : g_bad_counts
    $error("spmc_mode_control counts must be at least one");
  end

  // Thermal trip folds into the reset so every register returns to its start value.
  logic core_rst;
  assign core_rst = rst | thermal_shutdown; // RULE8

  spmc_state_e state_reg, state_next;
  spmc_term_t term_seen_reg, term_seen_next;
  logic powerup_reg, powerup_next;
  logic startup_block_reg, startup_block_next;
  logic gd_prev_reg, gd_prev_next;
  logic gd_kill_reg, gd_kill_next;
  logic gate_reg, gate_next;
  spmc_vsel_t vsel_reg, vsel_next;
  logic [1:0] hrst_cnt_reg, hrst_cnt_next;

  logic [CW-1:0] deb_count;
  logic [CW-1:0] gd_count;
  logic deb_clear;
  logic gd_run;
  logic term_valid;
  logic term_changed;

  assign term_valid = termination == `SPMC_TERM_SINK || termination == `SPMC_TERM_AUDIO ||
                      termination == `SPMC_TERM_DEBUG; // RULE2
  assign term_changed = termination != term_seen_reg;

  // Debounce restarts on every change and on every wake.
  assign deb_clear = term_changed || state_reg != SPMC_DEBOUNCE; // RULE12
  assign gd_run = state_reg == SPMC_ACTIVE && term_seen_reg == `SPMC_TERM_SINK && !gate_override_n;

  spmc_counter #(.WIDTH(CW)) u_deb (
    .clk(clk),
    .rst(core_rst),
    .clear(deb_clear),
    .run(1'h1),
    .count(deb_count)
  );

  spmc_counter #(.WIDTH(CW)) u_gd (
    .clk(clk),
    .rst(core_rst),
    .clear(!gd_run),
    .run(gd_run),
    .count(gd_count)
  );

  always_comb begin
    state_next = state_reg;
    term_seen_next = termination;
    hrst_cnt_next = hrst_cnt_reg;
    case (state_reg)
      SPMC_SLEEP: begin
        if (term_changed) begin
          state_next = SPMC_DEBOUNCE; // RULE4
        end
      end
      SPMC_DEBOUNCE: begin
        if (!term_changed && deb_count >= CW'(DEBOUNCE_CYCLES - 1)) begin
          // A dangling cable is not valid, so it lands back in sleep.
          state_next = term_valid ? SPMC_ACTIVE : SPMC_SLEEP; // RULE1 RULE3
        end
      end
      SPMC_ACTIVE: begin
        if (!term_valid) begin
          state_next = SPMC_DEBOUNCE; // RULE1
        end else if (gd_count >= CW'(GD_HOLD_CYCLES - 1)) begin
          state_next = SPMC_HARD_RESET; // RULE11
          hrst_cnt_next = 2'(`SPMC_HRST_CYCLES - 1);
        end
      end
      SPMC_HARD_RESET: begin
        if (hrst_cnt_reg == 2'h0) begin
          state_next = SPMC_DEBOUNCE; // RULE11
        end else begin
          hrst_cnt_next = hrst_cnt_reg - 2'h1;
        end
      end
      default: begin
        state_next = SPMC_SLEEP;
      end
    endcase
  end

  always_comb begin
    powerup_next = 1'h0;
    startup_block_next = startup_block_reg;
    if (powerup_reg) begin
      startup_block_next = vbus_above_uvlo; // RULE5
    end else if (!vbus_above_uvlo) begin
      startup_block_next = 1'h0;
    end
    gd_prev_next = gate_override_n;
    gd_kill_next = gd_kill_reg;
    if (gd_prev_reg && !gate_override_n) begin
      gd_kill_next = 1'h1; // RULE10
    end else if (gate_override_n) begin
      gd_kill_next = 1'h0;
    end
    gate_next = state_next == SPMC_ACTIVE && term_seen_next == `SPMC_TERM_SINK &&
                !startup_block_next && gate_override_n && !powerup_reg; // RULE5 RULE10
    vsel_next = `SPMC_VSEL_5V;
    if (state_next == SPMC_ACTIVE && term_seen_next == `SPMC_TERM_SINK) begin
      vsel_next = requested_level;
    end
  end

  always_ff @(posedge clk or posedge core_rst) begin
    if (core_rst) begin
      state_reg <= SPMC_SLEEP;
      term_seen_reg <= `SPMC_TERM_NONE;
      powerup_reg <= 1'h1;
      startup_block_reg <= 1'h1;
      gd_prev_reg <= 1'h1;
      gd_kill_reg <= 1'h0;
      gate_reg <= 1'h0;
      vsel_reg <= `SPMC_VSEL_5V;
      hrst_cnt_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      term_seen_reg <= term_seen_next;
      powerup_reg <= powerup_next;
      startup_block_reg <= startup_block_next;
      gd_prev_reg <= gd_prev_next;
      gd_kill_reg <= gd_kill_next;
      gate_reg <= gate_next;
      vsel_reg <= vsel_next;
      hrst_cnt_reg <= hrst_cnt_next;
    end
  end

  // The override also gates the pin directly so the cut-off costs no clock cycle.
  assign power_path_gate_drive = gate_reg & gate_override_n & ~gd_kill_reg; // RULE10
  assign sleep = state_reg == SPMC_SLEEP; // RULE1
  assign hard_reset = state_reg == SPMC_HARD_RESET; // RULE11
  assign core_supply_output = state_reg == SPMC_ACTIVE;
  // Open-drain outputs only ever pull low; released means enable off.
  assign supply_select_low_out = 1'h0;
  assign supply_select_high_out = 1'h0;
  assign supply_select_low_oe = vsel_reg == `SPMC_VSEL_12V ||
                                vsel_reg == `SPMC_VSEL_20V; // RULE6 RULE7 RULE9
  assign supply_select_high_oe = vsel_reg == `SPMC_VSEL_20V; // RULE7 RULE6 RULE9

  a_sleep_no_gate: assert property (@(posedge clk) disable iff (core_rst) // RULE1
    sleep |-> !power_path_gate_drive) else $error("gate on while asleep");
  a_valid_terms: assert property (@(posedge clk) disable iff (core_rst) // RULE2
    state_reg == SPMC_ACTIVE |-> term_seen_reg inside {`SPMC_TERM_SINK, `SPMC_TERM_AUDIO,
    `SPMC_TERM_DEBUG}) else $error("awake on invalid termination");
  a_dangle_sleeps: assert property (@(posedge clk) disable iff (core_rst) // RULE3
    termination == `SPMC_TERM_DANGLING && state_reg == SPMC_ACTIVE |=> state_reg != SPMC_ACTIVE)
    else $error("dangling cable kept awake");
  a_wake_change: assert property (@(posedge clk) disable iff (core_rst) // RULE4
    sleep && term_changed |=> state_reg == SPMC_DEBOUNCE) else $error("no wake on change");
  a_startup_block: assert property (@(posedge clk) disable iff (core_rst) // RULE5
    startup_block_reg |-> !power_path_gate_drive) else $error("gate on at live bus");
  a_sel_12v: assert property (@(posedge clk) disable iff (core_rst) // RULE6
    vsel_reg == `SPMC_VSEL_12V |-> supply_select_low_oe && !supply_select_high_oe)
    else $error("bad 12 V selects");
  a_sel_20v: assert property (@(posedge clk) disable iff (core_rst) // RULE7
    vsel_reg == `SPMC_VSEL_20V |-> supply_select_low_oe && supply_select_high_oe)
    else $error("bad 20 V selects");
  a_sel_5v: assert property (@(posedge clk) disable iff (core_rst) // RULE9
    vsel_reg == `SPMC_VSEL_5V |-> !supply_select_low_oe && !supply_select_high_oe)
    else $error("bad 5 V selects");
  a_asleep_selects: assert property (@(posedge clk) disable iff (core_rst) // RULE9
    sleep |-> !supply_select_low_oe && !supply_select_high_oe)
    else $error("selects pulled while asleep");
  a_override_off: assert property (@(posedge clk) disable iff (core_rst) // RULE10
    !gate_override_n |-> !power_path_gate_drive) else $error("override ignored");
  // The pin gating alone would hide a broken registered path, so that is watched too.
  a_override_reg: assert property (@(posedge clk) disable iff (core_rst) // RULE10
    !gate_override_n |=> !gate_reg) else $error("gate register on under override");
  a_hold_hrst: assert property (@(posedge clk) disable iff (core_rst) // RULE11
    gd_run && gd_count == CW'(GD_HOLD_CYCLES - 1) && term_valid |=> hard_reset)
    else $error("no hard reset after hold");
  a_hrst_len: assert property (@(posedge clk) disable iff (core_rst) // RULE11
    $rose(hard_reset) |-> hard_reset [*4] ##1 !hard_reset)
    else $error("hard reset pulse length wrong");
  a_wake_debounce: assert property (@(posedge clk) disable iff (core_rst) // RULE12
    state_reg == SPMC_SLEEP ##1 state_reg != SPMC_SLEEP |-> state_reg == SPMC_DEBOUNCE)
    else $error("woke without debounce");
endmodule : spmc_mode_control

// ==== spmc_regs.svh ====
// Constants for the source port mode controller.
`ifndef SPMC_REGS_SVH
`define SPMC_REGS_SVH
`define SPMC_CLK_PERIOD_NS 10
`define SPMC_GD_HOLD_MS 600
`define SPMC_GD_HOLD_CYCLES (`SPMC_GD_HOLD_MS * 1000000 / `SPMC_CLK_PERIOD_NS)
`define SPMC_DEBOUNCE_CYCLES 16
`define SPMC_HRST_CYCLES 4
`define SPMC_TERM_NONE 3'h0
`define SPMC_TERM_SINK 3'h1
`define SPMC_TERM_AUDIO 3'h2
`define SPMC_TERM_DEBUG 3'h3
`define SPMC_TERM_DANGLING 3'h4
`define SPMC_VSEL_5V 2'h0
`define SPMC_VSEL_12V 2'h1
`define SPMC_VSEL_20V 2'h2
`endif

// ==== spmc_pkg.sv ====
// Types for the source port mode controller.
package spmc_pkg;
  typedef enum logic [3:0] {
    SPMC_SLEEP = 4'h1,
    SPMC_DEBOUNCE = 4'h2,
    SPMC_ACTIVE = 4'h4,
    SPMC_HARD_RESET = 4'h8
  } spmc_state_e;
  typedef logic [2:0] spmc_term_t;
  typedef logic [1:0] spmc_vsel_t;
endpackage : spmc_pkg

// ==== spmc_counter.sv ====
// Saturating cycle counter used for debounce and override hold timing.
`timescale 1ns/1ns
module spmc_counter #(
  parameter int WIDTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic run,
  output logic [WIDTH-1:0] count
);
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  if (WIDTH < 2) begin : g_bad_width
    $error("spmc_counter needs at least two bits");
  end
  always_comb begin
    count_next = count_reg;
    if (clear) begin
      count_next = '0;
    end else if (run && count_reg != {WIDTH{1'h1}}) begin
      count_next = count_reg + WIDTH'(1);
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end
  assign count = count_reg;
endmodule : spmc_counter

// ==== spmc_sink_model.sv ====
// Behavioural sink and external supply facing the mode controller.
`timescale 1ns/1ns
`include "spmc_regs.svh"
module spmc_sink_model
  import spmc_pkg::*;
(
  input wire spmc_term_t term_cmd,
  input wire spmc_vsel_t level_cmd,
  input wire logic ext_live,
  input wire logic gate_on,
  input wire logic low_oe,
  input wire logic low_out,
  input wire logic high_oe,
  input wire logic high_out,
  output spmc_term_t termination,
  output spmc_vsel_t requested_level,
  output logic vbus_above_uvlo,
  output logic low_wire,
  output logic high_wire
);
  assign termination = term_cmd;
  // Only an attached sink makes a request, so others leave the default level.
  assign requested_level = (term_cmd == `SPMC_TERM_SINK) ? level_cmd : `SPMC_VSEL_5V;
  // The bus is live from a foreign supply or through our own switched path.
  assign vbus_above_uvlo = ext_live | gate_on;
  // Pull-ups hold released selects high, so a stale low can never pass.
  assign low_wire = low_oe ? low_out : 1'h1;
  assign high_wire = high_oe ? high_out : 1'h1;
endmodule : spmc_sink_model

// ==== spmc_tb.sv ====
// Self-checking bench for the source port mode controller.
`timescale 1ns/1ns
`include "spmc_regs.svh"
module testbench;
  import spmc_pkg::*;
  logic clk, rst, thermal_shutdown, gate_override_n, ext_live, vbus, sleep, gate;
  logic lo_out, lo_oe, hi_out, hi_oe, core, hard_reset, lo_w, hi_w;
  spmc_term_t term_cmd, term;
  spmc_vsel_t level_cmd, level;
  int mismatches = 0;
  int tests_run = 0;
  spmc_mode_control #(.GD_HOLD_CYCLES(50), .DEBOUNCE_CYCLES(4)) dut (.clk(clk), .rst(rst),
    .thermal_shutdown(thermal_shutdown), .termination(term), .vbus_above_uvlo(vbus),
    .requested_level(level), .gate_override_n(gate_override_n), .sleep(sleep),
    .power_path_gate_drive(gate), .supply_select_low_out(lo_out),
    .supply_select_low_oe(lo_oe), .supply_select_high_out(hi_out),
    .supply_select_high_oe(hi_oe), .core_supply_output(core), .hard_reset(hard_reset));
  spmc_sink_model far (.term_cmd(term_cmd), .level_cmd(level_cmd), .ext_live(ext_live),
    .gate_on(gate), .low_oe(lo_oe), .low_out(lo_out), .high_oe(hi_oe), .high_out(hi_out),
    .termination(term), .requested_level(level), .vbus_above_uvlo(vbus), .low_wire(lo_w),
    .high_wire(hi_w));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic finish_test;
    $display("Checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test
  // One change plus the full debounce of 4 edges and a cycle of margin.
  task automatic plug(input spmc_term_t t);
    term_cmd = t;
    cyc(6);
  endtask : plug
  task automatic startup_block;
    plug(`SPMC_TERM_SINK);
    check("sink awake", {sleep, core}, 8'h1);
    check("gate blocked", gate, 8'h0);
    ext_live = 0;
    cyc(3);
    check("gate freed", gate, 8'h1);
  endtask : startup_block
  task automatic levels;
    for (int l = 0; l < 3; l++) begin
      level_cmd = spmc_vsel_t'(l);
      cyc(2);
      check("low select", {lo_oe, lo_w}, (l != 0) ? 8'h2 : 8'h1);
      check("high select", {hi_oe, hi_w}, (l == 2) ? 8'h2 : 8'h1);
    end
  endtask : levels
  task automatic override;
    int n;
    n = 0;
    gate_override_n = 0;
    cyc(1);
    check("gate kill", gate, 8'h0);
    cyc(40);
    check("early hard reset", hard_reset, 8'h0);
    for (int i = 0; i < 30 && hard_reset !== 1'b1; i++) cyc(1);
    if (hard_reset !== 1'b1) begin
      check("hard reset seen", 8'h0, 8'h1);
      finish_test();
    end
    while (hard_reset === 1'b1 && n < 10) begin
      n++;
      cyc(1);
    end
    check("hard reset width", n[7:0], 8'(`SPMC_HRST_CYCLES));
    gate_override_n = 1;
    cyc(8);
    check("restart gate", gate, 8'h1);
  endtask : override
  task automatic accessories;
    plug(`SPMC_TERM_NONE);
    check("none sleeps", sleep, 8'h1);
    plug(`SPMC_TERM_AUDIO);
    check("audio awake", {sleep, core, gate}, 8'h2);
    plug(`SPMC_TERM_DEBUG);
    check("debug awake", {sleep, core, gate}, 8'h2);
    plug(`SPMC_TERM_DANGLING);
    check("dangling sleeps", sleep, 8'h1);
  endtask : accessories
  // A bouncing attach must not be acted on until it has settled afresh.
  task automatic bounce;
    term_cmd = `SPMC_TERM_SINK;
    cyc(3);
    term_cmd = `SPMC_TERM_NONE;
    cyc(2);
    term_cmd = `SPMC_TERM_SINK;
    cyc(2);
    check("bounce held", core, 8'h0);
    cyc(6);
    check("bounce done", {core, gate}, 8'h3);
  endtask : bounce
  task automatic trip;
    level_cmd = `SPMC_VSEL_20V;
    cyc(2);
    thermal_shutdown = 1;
    cyc(1);
    check("trip state", {sleep, gate, lo_oe, hi_oe, hard_reset}, 8'h10);
    thermal_shutdown = 0;
  endtask : trip
  initial begin
    rst = 1;
    thermal_shutdown = 0;
    gate_override_n = 1;
    ext_live = 1;
    term_cmd = `SPMC_TERM_NONE;
    level_cmd = `SPMC_VSEL_5V;
    cyc(16);
    check("reset state", {sleep, gate, lo_oe, hi_oe}, 8'h8);
    rst = 0;
    cyc(2);
    startup_block();
    levels();
    override();
    accessories();
    bounce();
    trip();
    finish_test();
  end
endmodule : testbench
